// File: arf_formatter.sv
// Converter result formatter: control register, completion and window flags, result bytes.
// Assumes the analog core reports a raw code with a busy level and a window-hit strobe.
//
// What this block does
// [RULE1] Each 10-bit result is stored across a high and low byte register, placed per the justify bit.
// [RULE2] Right justified: result 9:8 in high 1:0, 7:0 in low, high 7:2 zero for single-ended.
// [RULE3] Right justified differential: high 7:2 copy high bit 1 as sign extension.
// [RULE4] Left justified: result 9:2 in high, 1:0 in low 7:6, low 5:0 zero.
// [RULE5] Single-ended codes have 10 magnitude bits, differential codes 9 bits plus sign.
// [RULE6] Differential negative full scale reads 0xFE00 right justified and 0x8000 left justified.
// [RULE7] The done flag sets on the falling edge of busy and holds until software clears it.
// [RULE8] With start source 00b, writing one to busy starts a conversion; writing zero does nothing.
// [RULE9] A window-compare flag sets when a result meets the limit test and software clears it.
// [RULE10] Both result bytes update in the same cycle the done flag sets.
`timescale 1ns/100ps
module arf_formatter
    import arf_pkg::*;
(
    input  wire logic                    CLK_IN,
    input  wire logic                    NRST_IN,
    input  wire logic [7:0]              SFR_ADDR_IN,
    input  wire logic [7:0]              SFR_WDATA_IN,
    input  wire logic                    SFR_WR_IN,
    input  wire logic                    SFR_RD_IN,
    output logic      [7:0]              SFR_RDATA_OUT,
    input  wire logic                    DIFF_MODE_IN,
    input  wire logic                    CONV_BUSY_IN,
    input  wire logic [RESULT_WIDTH-1:0] CONV_CODE_IN,
    input  wire logic                    WINDOW_HIT_IN,
    output logic                         CONV_START_OUT,
    output logic                         ENABLE_OUT,
    output logic                         TRACK_MODE_OUT,
    output logic      [1:0]              START_SOURCE_OUT,
    output logic                         DIFF_ACTIVE_OUT
);
    logic [7:0] control_reg, control_next;
    logic [7:0] low_reg, low_next;
    logic [7:0] high_reg, high_next;
    logic       busy_d_reg;
    logic       start_reg;
    logic       diff_reg;
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] fmt_high, fmt_low;

    wire wr_ctl  = SFR_WR_IN & (SFR_ADDR_IN == ADDR_CONTROL);
    wire wr_low  = SFR_WR_IN & (SFR_ADDR_IN == ADDR_RESULT_LOW);
    wire wr_high = SFR_WR_IN & (SFR_ADDR_IN == ADDR_RESULT_HIGH);
    wire busy_fall = busy_d_reg & ~CONV_BUSY_IN;                        // see [RULE7]
    wire sw_start  = wr_ctl & SFR_WDATA_IN[CTL_BUSY_BIT]
                   & (control_reg[CTL_STM_LSB+:2] == STM_SOFTWARE);     // see [RULE8]
    wire done_set  = busy_fall;
    wire wint_set  = busy_fall & WINDOW_HIT_IN;                         // see [RULE9]

    // Differential codes keep 9 bits plus sign; single-ended uses all 10 bits
    arf_justify u_justify (                                             // see [RULE5] see [RULE6]
        .code_in  (CONV_CODE_IN),
        .left_in  (control_reg[CTL_LJUST_BIT]),
        .diff_in  (DIFF_MODE_IN),
        .high_out (fmt_high),
        .low_out  (fmt_low)
    );

    // Control: software fields written, flags set by hardware win over clear
    always_comb begin
        control_next = control_reg;
        if (wr_ctl) begin
            control_next = SFR_WDATA_IN;
        end
        control_next[CTL_BUSY_BIT] = CONV_BUSY_IN | start_reg | sw_start;
        if (done_set) begin
            control_next[CTL_DONE_BIT] = 1'b1;                          // see [RULE7]
        end
        if (wint_set) begin
            control_next[CTL_WINT_BIT] = 1'b1;                          // see [RULE9]
        end
    end

    // Results load together with the done flag
    assign low_next  = done_set ? fmt_low  : (wr_low  ? SFR_WDATA_IN : low_reg);   // see [RULE10]
    assign high_next = done_set ? fmt_high : (wr_high ? SFR_WDATA_IN : high_reg);  // see [RULE10]

    assign rdata_next = !SFR_RD_IN                       ? 8'h00 :
                        (SFR_ADDR_IN == ADDR_CONTROL)     ? control_reg :
                        (SFR_ADDR_IN == ADDR_RESULT_LOW)  ? low_reg :
                        (SFR_ADDR_IN == ADDR_RESULT_HIGH) ? high_reg : 8'h00;

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            control_reg <= CONTROL_RESET;
            low_reg     <= RESULT_RESET;
            high_reg    <= RESULT_RESET;
            busy_d_reg  <= 1'b0;
            start_reg   <= 1'b0;
            diff_reg    <= 1'b0;
            rdata_reg   <= 8'h00;
        end else begin
            control_reg <= control_next;
            low_reg     <= low_next;
            high_reg    <= high_next;
            busy_d_reg  <= CONV_BUSY_IN;
            start_reg   <= sw_start;                                    // see [RULE8]
            diff_reg    <= DIFF_MODE_IN;
            rdata_reg   <= rdata_next;
        end
    end

    assign SFR_RDATA_OUT    = rdata_reg;
    assign CONV_START_OUT   = start_reg;
    assign ENABLE_OUT       = control_reg[CTL_ENABLE_BIT];
    assign TRACK_MODE_OUT   = control_reg[CTL_TRACK_BIT];
    assign START_SOURCE_OUT = control_reg[CTL_STM_LSB+:2];
    assign DIFF_ACTIVE_OUT  = diff_reg;
endmodule

// File: arf_formatter_props.sv
// Checker on the formatter ports: start pulse, read data and control bits.
// Assumes it is bound to arf_formatter with one clock.
`timescale 1ns/100ps
module arf_formatter_props
    import arf_pkg::*;
(
    input wire logic       CLK_IN,
    input wire logic       NRST_IN,
    input wire logic [7:0] SFR_ADDR_IN,
    input wire logic [7:0] SFR_WDATA_IN,
    input wire logic       SFR_WR_IN,
    input wire logic       SFR_RD_IN,
    input wire logic [7:0] SFR_RDATA_OUT,
    input wire logic       CONV_BUSY_IN,
    input wire logic       CONV_START_OUT,
    input wire logic [1:0] START_SOURCE_OUT
);
    wire wr_ctl = SFR_WR_IN && SFR_ADDR_IN == ADDR_CONTROL;
    wire rd_ctl = SFR_RD_IN && !SFR_WR_IN && SFR_ADDR_IN == ADDR_CONTROL;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    start_pulse_a: assert property (wr_ctl && SFR_WDATA_IN[CTL_BUSY_BIT]
        && START_SOURCE_OUT == STM_SOFTWARE |=> CONV_START_OUT) else $error("start pulse missing");
    start_source_a: assert property (wr_ctl && START_SOURCE_OUT != STM_SOFTWARE
        |=> !CONV_START_OUT) else $error("start with other source");
    start_zero_a: assert property (wr_ctl && !SFR_WDATA_IN[CTL_BUSY_BIT] |=> !CONV_START_OUT)
        else $error("start on zero write");
    start_addr_a: assert property (SFR_WR_IN && !wr_ctl |=> !CONV_START_OUT)
        else $error("start from other address");
    start_once_a: assert property (CONV_START_OUT && !SFR_WR_IN |=> !CONV_START_OUT)
        else $error("start pulse too long");
    read_idle_a: assert property (!SFR_RD_IN |=> SFR_RDATA_OUT == 8'h00)
        else $error("read data without read");
    read_unmapped_a: assert property (SFR_RD_IN && SFR_ADDR_IN == 8'h00 |=> SFR_RDATA_OUT == 8'h00)
        else $error("unmapped read data");
    done_read_a: assert property ($fell(CONV_BUSY_IN) && !SFR_WR_IN ##1 !SFR_WR_IN ##1 rd_ctl
        |=> SFR_RDATA_OUT[CTL_DONE_BIT]) else $error("done flag not set");
    justify_back_a: assert property (wr_ctl ##1 rd_ctl
        |=> SFR_RDATA_OUT[0] == $past(SFR_WDATA_IN[0], 2)) else $error("justify bit lost");
endmodule
bind arf_formatter arf_formatter_props i_props (.*);

// File: arf_justify.sv
// Justifier: maps a 10-bit conversion code to the high/low byte pair.
// Assumes a combinational use inside the formatter; no clock.
`timescale 1ns/100ps
module arf_justify
    import arf_pkg::*;
(
    input  wire logic [RESULT_WIDTH-1:0] code_in,
    input  wire logic                    left_in,
    input  wire logic                    diff_in,
    output logic      [7:0]              high_out,
    output logic      [7:0]              low_out
);
    wire       ext_bit = diff_in & code_in[9];
    wire [7:0] r_high  = {{6{ext_bit}}, code_in[9:8]};                  // see [RULE2] see [RULE3]
    wire [7:0] l_high  = code_in[9:2];                                  // see [RULE4]
    wire [7:0] l_low   = {code_in[1:0], 6'h00};                         // see [RULE4]
    assign high_out = left_in ? l_high : r_high;                        // see [RULE1]
    assign low_out  = left_in ? l_low  : code_in[7:0];                  // see [RULE2]
endmodule

// File: arf_pkg.sv
// Package for the converter result formatter: register addresses, fields, reset values.
// Assumes an 8-bit special-function-register bus with 8-bit addresses.
package arf_pkg;
    localparam logic [7:0] ADDR_RESULT_LOW  = 8'hBE;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hBF;
    localparam logic [7:0] ADDR_CONTROL     = 8'hE8;
    localparam int         CTL_ENABLE_BIT   = 7;
    localparam int         CTL_TRACK_BIT    = 6;
    localparam int         CTL_DONE_BIT     = 5;
    localparam int         CTL_BUSY_BIT     = 4;
    localparam int         CTL_STM_LSB      = 2;
    localparam int         CTL_WINT_BIT     = 1;
    localparam int         CTL_LJUST_BIT    = 0;
    localparam logic [1:0] STM_SOFTWARE     = 2'h0;
    localparam logic [7:0] RESULT_RESET     = 8'h00;
    localparam logic [7:0] CONTROL_RESET    = 8'h00;
    localparam int         RESULT_WIDTH     = 10;
endpackage

// File: tb_arf_formatter.sv
// Testbench: register reads and writes, conversions in all justify modes.
// Assumes the design and its checker are compiled first.
`timescale 1ns/100ps
module tb_arf_formatter import arf_pkg::*; ;
    logic       CLK_IN = 0, NRST_IN = 0, SFR_WR_IN = 0, SFR_RD_IN = 0;
    logic       DIFF_MODE_IN = 0, CONV_BUSY_IN = 0, WINDOW_HIT_IN = 0, CONV_START_OUT;
    logic [7:0] SFR_ADDR_IN = 8'h00, SFR_WDATA_IN = 8'h00, SFR_RDATA_OUT;
    logic [9:0] CONV_CODE_IN = 10'h000;
    logic       ENABLE_OUT, TRACK_MODE_OUT, DIFF_ACTIVE_OUT;
    logic [1:0] START_SOURCE_OUT;
    int         errors = 0, checks = 0;
    arf_formatter i_dut (.*);
    always #25 CLK_IN = ~CLK_IN;
    task chk(input logic [7:0] a, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] reg %h expected %h seen %h", a, exp, seen);
        end
    endtask
    task op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        SFR_WR_IN = w;
        SFR_RD_IN = r;
        SFR_ADDR_IN = a;
        SFR_WDATA_IN = d;
        @(negedge CLK_IN);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        op(0, 1, a, 8'h00);
        chk(a, SFR_RDATA_OUT, exp);
    endtask
    task conv(input logic [9:0] c, input logic df, input logic lj, input logic win,
              input logic [15:0] word);
        DIFF_MODE_IN = df;
        op(1, 0, ADDR_CONTROL, 8'h90 | lj);
        chk(8'hF0, {7'h00, CONV_START_OUT}, 8'h01);
        chk(8'hF1, {7'h00, DIFF_ACTIVE_OUT}, {7'h00, df});
        CONV_BUSY_IN = 1;
        CONV_CODE_IN = c;
        WINDOW_HIT_IN = win;
        repeat (3) op(0, 0, 8'h00, 8'h00);
        CONV_BUSY_IN = 0;
        repeat (2) op(0, 0, 8'h00, 8'h00);
        rd(ADDR_CONTROL, 8'hA0 | lj | {win, 1'b0});
        rd(ADDR_RESULT_HIGH, word[15:8]);
        rd(ADDR_RESULT_LOW, word[7:0]);
    endtask
    task summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge CLK_IN);
        NRST_IN = 1;
        rd(ADDR_RESULT_LOW, RESULT_RESET);
        rd(ADDR_RESULT_HIGH, RESULT_RESET);
        rd(ADDR_CONTROL, CONTROL_RESET);
        rd(8'h00, 8'h00);
        op(1, 0, ADDR_RESULT_LOW, 8'h5A);
        rd(ADDR_RESULT_LOW, 8'h5A);
        conv(10'h3FF, 0, 0, 0, 16'h03FF);
        conv(10'h3FF, 0, 1, 1, 16'hFFC0);
        conv(10'h200, 1, 0, 0, 16'hFE00);
        conv(10'h200, 1, 1, 0, 16'h8000);
        conv(10'h1FF, 1, 0, 1, 16'h01FF);
        conv(10'h200, 0, 0, 0, 16'h0200);
        op(1, 0, ADDR_CONTROL, 8'h80);
        rd(ADDR_CONTROL, 8'h80);
        chk(8'hF2, {7'h00, ENABLE_OUT}, 8'h01);
        op(1, 0, ADDR_CONTROL, 8'hCC);
        op(1, 0, ADDR_CONTROL, 8'hDC);
        chk(8'hF0, {7'h00, CONV_START_OUT}, 8'h00);
        rd(ADDR_CONTROL, 8'hCC);
        chk(8'hF3, {7'h00, TRACK_MODE_OUT}, 8'h01);
        chk(8'hF4, {6'h00, START_SOURCE_OUT}, 8'h03);
        summarize();
    end
    initial begin
        #100000;
        errors++;
        summarize();
    end
endmodule
